// File: cmpo_can_node_model.sv
`timescale 1ns/1ps
module cmpo_can_node_model
  import cmpo_pkg::*;
(
  input wire logic ref_clk, // System clock
  input wire logic tx_start, // Frame handed over
  output logic eng_tx_ready, // Bus free for a frame
  output logic eng_tx_done, // Frame finished
  output logic eng_rx_valid, // Frame received
  output logic [NUM_OBJ-1:0] eng_rx_match, // Tag hits
  output logic [3:0] eng_rx_dlc, // Received length
  output logic eng_rx_remote, // Remote frame
  output logic [ERR_W-1:0] eng_err // Error pulses
);
  int done_lat = 4;

  initial begin
    {eng_tx_ready, eng_tx_done, eng_rx_valid, eng_rx_remote} = '0;
    eng_rx_match = '0;
    eng_rx_dlc = 4'h0;
    eng_err = '0;
  end

  task automatic ready(input logic b);
    @(posedge ref_clk);
    #1;
    eng_tx_ready = b;
  endtask : ready

  // Qualifiers flip to the inverse once the frame is gone
  task automatic rx_frame(input logic [NUM_OBJ-1:0] m,
    input logic [3:0] d, input logic r);
    @(posedge ref_clk);
    #1;
    eng_rx_valid = 1'b1;
    eng_rx_match = m;
    eng_rx_dlc = d;
    eng_rx_remote = r;
    @(posedge ref_clk);
    #1;
    eng_rx_valid = 1'b0;
    eng_rx_match = ~m;
    eng_rx_dlc = ~d;
    eng_rx_remote = ~r;
  endtask : rx_frame

  task automatic err_pulse(input logic [ERR_W-1:0] e);
    @(posedge ref_clk);
    #1;
    eng_err = e;
    @(posedge ref_clk);
    #1;
    eng_err = '0;
  endtask : err_pulse

  always begin
    @(posedge ref_clk);
    #1;
    if (tx_start === 1'b1) begin
      repeat (done_lat) @(posedge ref_clk);
      #1;
      eng_tx_done = 1'b1;
      @(posedge ref_clk);
      #1;
      eng_tx_done = 1'b0;
    end
  end
endmodule : cmpo_can_node_model

// File: cmpo_data_buf.sv
`timescale 1ns/1ps
module cmpo_data_buf
  import cmpo_pkg::*;
(
  input wire logic ref_clk, // System clock
  cmpo_data_if.mem dp // Data field port
);
  typedef struct packed {
    logic [NUM_OBJ-1:0][NUM_BYTES-1:0][7:0] mem;
  } cmpo_buf_s;

  cmpo_buf_s s;
  cmpo_buf_s next_s;

  always_comb begin
    next_s = s;
    if (dp.wr && obj_ok(dp.obj)) begin
      next_s.mem[dp.obj][dp.idx] = dp.wdata; // see R3
    end
  end

  assign dp.rdata = obj_ok(dp.obj) ? s.mem[dp.obj][dp.idx] : READ_NONE;

  always_ff @(posedge ref_clk) begin
    s <= next_s;
  end
endmodule : cmpo_data_buf

// File: cmpo_data_if.sv
`timescale 1ns/1ps
interface cmpo_data_if;
  import cmpo_pkg::*;
  logic [OBJ_W-1:0] obj;
  logic [IDX_W-1:0] idx;
  logic wr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport ctl (output obj, output idx, output wr, output wdata,
    input rdata);
  modport mem (input obj, input idx, input wr, input wdata,
    output rdata);
endinterface : cmpo_data_if

// File: cmpo_low_pick.sv
`timescale 1ns/1ps
module cmpo_low_pick
  import cmpo_pkg::*;
#(
  parameter int N = NUM_OBJ
) (
  input wire logic [N-1:0] req, // Candidate objects
  output logic found, // Any candidate present
  output logic [OBJ_W-1:0] pick // Lowest candidate index
);
  always_comb begin
    found = |req;
    pick = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i]) begin
        pick = OBJ_W'(i);
      end
    end
  end
endmodule : cmpo_low_pick

// File: cmpo_obj_page.sv
`timescale 1ns/1ps
module cmpo_obj_page
  import cmpo_pkg::*;
(
  input wire logic ref_clk, // System clock
  input wire logic rst_b, // Synchronous reset, active low
  input wire logic [7:0] sfr_addr, // Register address
  input wire logic sfr_wr, // Register write strobe
  input wire logic sfr_rd, // Register read strobe
  input wire logic [7:0] sfr_wdata, // Register write data
  output logic [7:0] sfr_rdata, // Read data, one cycle after strobe
  input wire logic eng_tx_ready, // Engine can start a frame
  input wire logic eng_tx_done, // Transmission completed
  input wire logic eng_rx_valid, // Received frame complete
  input wire logic [NUM_OBJ-1:0] eng_rx_match, // Objects whose tag hit
  input wire logic [3:0] eng_rx_dlc, // Received length code
  input wire logic eng_rx_remote, // Received frame was remote
  input wire logic [ERR_W-1:0] eng_err, // Bit,stuff,crc,form,ack pulses
  output logic tx_start, // Pulse: object handed to engine
  output logic tx_busy, // Transmission in progress
  output logic [OBJ_W-1:0] tx_obj, // Object being sent
  output logic tx_ide, // Extended identifier for tx_obj
  output logic [3:0] tx_dlc, // Length code for tx_obj
  output logic rx_upd, // Pulse: receive object updated
  output logic [OBJ_W-1:0] rx_obj // Last updated receive object
);
  typedef struct packed {
    logic [7:0] page;
    logic [NUM_OBJ-1:0][7:0] ctrl;
    logic [NUM_OBJ-1:0][7:0] stat;
    cmpo_tx_e txst;
    logic tx_start;
    logic [OBJ_W-1:0] tx_obj;
    logic tx_ide;
    logic [3:0] tx_dlc;
    logic rx_upd;
    logic [OBJ_W-1:0] rx_obj;
    logic [7:0] rdata;
  } cmpo_main_s;

  cmpo_main_s s;
  cmpo_main_s next_s;

  logic [OBJ_W-1:0] sel;
  logic [IDX_W-1:0] idx;
  logic inc_dis;
  logic data_acc;
  logic [NUM_OBJ-1:0] tx_pend;
  logic [NUM_OBJ-1:0] rx_en;
  logic tx_found;
  logic rx_found;
  logic [OBJ_W-1:0] tx_pick;
  logic [OBJ_W-1:0] rx_pick;
  logic busy;
  logic [OBJ_W-1:0] err_obj;
  logic [ERR_W-1:0] err_hit;

  cmpo_data_if dif ();

  assign sel = s.page[PG_OBJ_MSB:PG_OBJ_LSB]; // see R1
  assign idx = s.page[PG_IDX_MSB:PG_IDX_LSB]; // see R3
  assign inc_dis = s.page[PG_INC_DIS];
  assign data_acc = (sfr_wr || sfr_rd) && (sfr_addr == ADDR_DATA);
  assign busy = (s.txst == TX_BUSY);

  assign dif.obj = sel;
  assign dif.idx = idx;
  assign dif.wr = sfr_wr && (sfr_addr == ADDR_DATA);
  assign dif.wdata = sfr_wdata;

  // Objects take part in arbitration only by their configuration
  for (genvar i = 0; i < NUM_OBJ; i++) begin : g_obj
    assign tx_pend[i] = (cfg_of(s.ctrl[i]) == CFG_TX); // see R5, R20
    assign rx_en[i] = (cfg_of(s.ctrl[i]) == CFG_RX); // see R5, R20
  end

  cmpo_low_pick #(.N(NUM_OBJ)) u_tx_pick (
    .req(tx_pend), // see R12
    .found(tx_found),
    .pick(tx_pick)
  );

  cmpo_low_pick #(.N(NUM_OBJ)) u_rx_pick (
    .req(eng_rx_match & rx_en), // see R14
    .found(rx_found),
    .pick(rx_pick)
  );

  cmpo_data_buf u_data (
    .ref_clk(ref_clk),
    .dp(dif.mem)
  );

  // Errors go to the object in service
  assign err_obj = busy ? s.tx_obj : s.rx_obj;
  assign err_hit = eng_err & (busy ? ERR_ANY : ERR_RX_ONLY); // see R15, R19

  always_comb begin
    next_s = s;
    next_s.tx_start = 1'b0;
    next_s.rx_upd = 1'b0;
    next_s.rdata = READ_NONE;
    // Software writes first so that hardware events win the same cycle
    if (sfr_wr) begin
      case (sfr_addr)
        ADDR_PAGE: next_s.page = sfr_wdata; // see R1
        ADDR_CTRL: begin
          if (obj_ok(sel)) begin
            next_s.ctrl[sel] = sfr_wdata; // see R5, R7, R8, R20
          end
        end
        ADDR_STAT: begin
          if (obj_ok(sel)) begin
            next_s.stat[sel] = sfr_wdata; // see R11, R13, R16
          end
        end
        default: ;
      endcase
    end
    if (data_acc && !inc_dis) begin
      next_s.page[PG_IDX_MSB:PG_IDX_LSB] = idx + IDX_W'(1); // see R2
    end
    if (sfr_rd) begin
      case (sfr_addr)
        ADDR_PAGE: next_s.rdata = s.page;
        ADDR_CTRL: next_s.rdata = obj_ok(sel) ? s.ctrl[sel] : READ_NONE;
        ADDR_STAT: next_s.rdata = obj_ok(sel) ? s.stat[sel] : READ_NONE;
        ADDR_DATA: next_s.rdata = dif.rdata; // see R3
        default: next_s.rdata = READ_NONE;
      endcase
    end
    if (obj_ok(err_obj)) begin
      next_s.stat[err_obj][ST_BIT_ERROR_FLAG:ST_ERR_LSB] =
        s.stat[err_obj][ST_BIT_ERROR_FLAG:ST_ERR_LSB] | err_hit; // see R15-R19
      if (sfr_wr && sfr_addr == ADDR_STAT && sel == err_obj) begin
        next_s.stat[err_obj][ST_BIT_ERROR_FLAG:ST_ERR_LSB] =
          sfr_wdata[ST_BIT_ERROR_FLAG:ST_ERR_LSB] | err_hit; // see R16, R17
      end
    end
    case (s.txst)
      TX_IDLE: begin
        if (eng_tx_ready && tx_found) begin
          next_s.txst = TX_BUSY; // see R12
          next_s.tx_start = 1'b1;
          next_s.tx_obj = tx_pick;
          next_s.tx_ide = s.ctrl[tx_pick][CT_IDE]; // see R7
          next_s.tx_dlc = s.ctrl[tx_pick][CT_DLC_MSB:CT_DLC_LSB]; // see R8
        end
      end
      TX_BUSY: begin
        if (eng_tx_done) begin
          next_s.txst = TX_IDLE;
          next_s.stat[s.tx_obj][ST_TRANSMIT_DONE] = 1'b1; // see R11
          next_s.ctrl[s.tx_obj][CT_CFG_MSB:CT_CFG_LSB] = CFG_OFF;
        end
      end
      default: next_s.txst = TX_IDLE;
    endcase
    if (eng_rx_valid && rx_found) begin
      next_s.rx_upd = 1'b1;
      next_s.rx_obj = rx_pick; // see R14
      if (eng_rx_dlc != s.ctrl[rx_pick][CT_DLC_MSB:CT_DLC_LSB]) begin
        next_s.stat[rx_pick][ST_LENGTH_WARNING] = 1'b1; // see R10
      end
      next_s.ctrl[rx_pick][CT_DLC_MSB:CT_DLC_LSB] = eng_rx_dlc; // see R9
      next_s.stat[rx_pick][ST_RECEIVE_DONE] = 1'b1; // see R13
      if (eng_rx_remote && s.ctrl[rx_pick][CT_REPLY_VALID]) begin
        next_s.ctrl[rx_pick][CT_CFG_MSB:CT_CFG_LSB] = CFG_TX; // see R6
      end else begin
        next_s.ctrl[rx_pick][CT_CFG_MSB:CT_CFG_LSB] = CFG_OFF;
      end
    end
    if (!rst_b) begin
      next_s = '0;
      next_s.page = PAGE_RST; // see R4
      next_s.ctrl = {NUM_OBJ{CTRL_RST}};
      next_s.stat = {NUM_OBJ{STAT_RST}};
      next_s.txst = TX_IDLE;
    end
  end

  always_ff @(posedge ref_clk) begin
    s <= next_s;
  end

  assign sfr_rdata = s.rdata;
  assign tx_start = s.tx_start;
  assign tx_busy = busy;
  assign tx_obj = s.tx_obj;
  assign tx_ide = s.tx_ide;
  assign tx_dlc = s.tx_dlc;
  assign rx_upd = s.rx_upd;
  assign rx_obj = s.rx_obj;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);

  chk_page_reset: assert property ($rose(rst_b) |-> s.page == PAGE_RST) // see R4
    else $error("page not cleared by reset");
  chk_page_write: assert property (
    sfr_wr && sfr_addr == ADDR_PAGE |=> s.page == $past(sfr_wdata)) // see R1
    else $error("page write not stored");
  chk_index_step: assert property (
    data_acc && !inc_dis |=> idx == $past(idx) + IDX_W'(1)) // see R2
    else $error("index did not advance");
  chk_index_hold: assert property (data_acc && inc_dis |=> $stable(s.page)) // see R2
    else $error("index moved while stepping disabled");
  chk_tx_lowest: assert property (
    s.tx_start |-> ($past(tx_pend) & low_mask(s.tx_obj)) == '0) // see R12
    else $error("lower pending object skipped");
  chk_tx_launch: assert property (
    !busy && eng_tx_ready && tx_found |=> s.tx_start ##1 !s.tx_start) // see R5
    else $error("pending object not launched");
  chk_tx_done: assert property (
    busy && eng_tx_done |=> !busy && s.stat[s.tx_obj][ST_TRANSMIT_DONE]) // see R11
    else $error("transmit done flag missing");
  chk_rx_lowest: assert property (
    s.rx_upd |-> ($past(eng_rx_match & rx_en) & low_mask(s.rx_obj)) == '0) // see R14
    else $error("lower receive object skipped");
  chk_rx_length: assert property (s.rx_upd |-> s.stat[s.rx_obj][ST_RECEIVE_DONE]
    && s.ctrl[s.rx_obj][CT_DLC_MSB:CT_DLC_LSB] == $past(eng_rx_dlc)) // see R9
    else $error("received length not stored");
  chk_bit_error: assert property (
    busy && eng_err[ST_BIT_ERROR_FLAG] |=> s.stat[$past(s.tx_obj)][ST_BIT_ERROR_FLAG]) // see R15
    else $error("bit error not flagged");

  cov_tx_frame: cover property (s.tx_start ##[1:20] !busy);
  cov_rx_reply: cover property (eng_rx_valid && eng_rx_remote && rx_found);
  cov_len_warn: cover property (s.rx_upd && s.stat[s.rx_obj][ST_LENGTH_WARNING]);
endmodule : cmpo_obj_page

// File: cmpo_pkg.sv
// Summary of operation
// R1 - Page object field selects addressed object 0..14
// R2 - Index steps after data access unless disabled
// R3 - Index field picks byte of data field
// R4 - Page register resets to all zeros
// R5 - Config 01 launches transmit, 10 enables receive
// R6 - Remote frame answered only when reply valid
// R7 - Extension bit picks 11 or 29 bit identifier
// R8 - Length code counts data bytes, 0 to 8; codes 9 to 15 are stored and sent on without clamping
// R9 - Received frame overwrites stored length code
// R10 - Length mismatch sets warning, length still stored
// R11 - Transmit done flag set, software clears it
// R12 - Lowest pending transmit object sent first
// R13 - Receive done flag set, software clears it
// R14 - Lowest matching receive object updated first
// R15 - Bit error flagged only while transmitting
// R16 - Stuff error flag set, software clears it
// R17 - CRC mismatch sets CRC error flag
// R18 - Fixed form violation sets form error flag
// R19 - Missing acknowledge on own frame flagged
// R20 - Config 00 disables the object
package cmpo_pkg;
  localparam int NUM_OBJ = 15;
  localparam int OBJ_W = 4;
  localparam int IDX_W = 3;
  localparam int NUM_BYTES = 8;
  localparam int ERR_W = 5;

  localparam logic [7:0] ADDR_PAGE = 8'hb1;
  localparam logic [7:0] ADDR_STAT = 8'hb2;
  localparam logic [7:0] ADDR_CTRL = 8'hb3;
  localparam logic [7:0] ADDR_DATA = 8'hb4;

  localparam logic [7:0] PAGE_RST = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] STAT_RST = 8'h00;
  localparam logic [7:0] READ_NONE = 8'h00;

  // Page fields
  localparam int PG_OBJ_MSB = 7;
  localparam int PG_OBJ_LSB = 4;
  localparam int PG_INC_DIS = 3;
  localparam int PG_IDX_MSB = 2;
  localparam int PG_IDX_LSB = 0;

  // Control fields
  localparam int CT_CFG_MSB = 7;
  localparam int CT_CFG_LSB = 6;
  localparam int CT_REPLY_VALID = 5;
  localparam int CT_IDE = 4;
  localparam int CT_DLC_MSB = 3;
  localparam int CT_DLC_LSB = 0;

  // Status fields; error bits 4..0 line up with eng_err
  localparam int ST_LENGTH_WARNING = 7;
  localparam int ST_TRANSMIT_DONE = 6;
  localparam int ST_RECEIVE_DONE = 5;
  localparam int ST_BIT_ERROR_FLAG = 4;
  localparam int ST_ERR_LSB = 0;

  localparam logic [1:0] CFG_OFF = 2'h0;
  localparam logic [1:0] CFG_TX = 2'h1;
  localparam logic [1:0] CFG_RX = 2'h2;
  localparam logic [3:0] DLC_MAX = 4'h8;

  // Bit and acknowledge errors count only against an own transmission
  localparam logic [ERR_W-1:0] ERR_ANY = 5'h1f;
  localparam logic [ERR_W-1:0] ERR_RX_ONLY = 5'h0e;

  typedef enum logic [0:0] {TX_IDLE, TX_BUSY} cmpo_tx_e;

  function automatic logic obj_ok(input logic [OBJ_W-1:0] o);
    return o < OBJ_W'(NUM_OBJ);
  endfunction : obj_ok

  function automatic logic [1:0] cfg_of(input logic [7:0] c);
    return c[CT_CFG_MSB:CT_CFG_LSB];
  endfunction : cfg_of

  function automatic logic [NUM_OBJ-1:0] low_mask(
    input logic [OBJ_W-1:0] o);
    return (NUM_OBJ'(1) << o) - NUM_OBJ'(1);
  endfunction : low_mask
endpackage : cmpo_pkg

// File: tb_cmpo_obj_page.sv
`timescale 1ns/1ps
module tb_cmpo_obj_page;
  import cmpo_pkg::*;
  logic ref_clk, rst_b, sfr_wr, sfr_rd;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, rv;
  logic eng_tx_ready, eng_tx_done, eng_rx_valid, eng_rx_remote;
  logic [NUM_OBJ-1:0] eng_rx_match;
  logic [3:0] eng_rx_dlc, tx_dlc;
  logic [ERR_W-1:0] eng_err;
  logic tx_start, tx_busy, tx_ide, rx_upd;
  logic [OBJ_W-1:0] tx_obj, rx_obj;
  int bad_count = 0;
  int n_tests = 0;

  cmpo_obj_page cmpo_obj_page_inst (.ref_clk(ref_clk), .rst_b(rst_b),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .eng_tx_ready(eng_tx_ready), .eng_tx_done(eng_tx_done),
    .eng_rx_valid(eng_rx_valid), .eng_rx_match(eng_rx_match),
    .eng_rx_dlc(eng_rx_dlc), .eng_rx_remote(eng_rx_remote),
    .eng_err(eng_err), .tx_start(tx_start), .tx_busy(tx_busy),
    .tx_obj(tx_obj), .tx_ide(tx_ide), .tx_dlc(tx_dlc),
    .rx_upd(rx_upd), .rx_obj(rx_obj));

  cmpo_can_node_model node_inst (.ref_clk(ref_clk), .tx_start(tx_start),
    .eng_tx_ready(eng_tx_ready), .eng_tx_done(eng_tx_done),
    .eng_rx_valid(eng_rx_valid), .eng_rx_match(eng_rx_match),
    .eng_rx_dlc(eng_rx_dlc), .eng_rx_remote(eng_rx_remote),
    .eng_err(eng_err));

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  task automatic close_out();
    $display("Checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : close_out

  task automatic chk(input string nm, input logic [7:0] e,
    input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    #1;
    sfr_wr = 1'b1;
    sfr_addr = a;
    sfr_wdata = d;
    @(posedge ref_clk);
    #1;
    sfr_wr = 1'b0;
  endtask : wr

  // Read data is registered: sampled in the cycle after the strobe
  task automatic rchk(input string nm, input logic [7:0] a,
    input logic [7:0] e);
    @(posedge ref_clk);
    #1;
    sfr_rd = 1'b1;
    sfr_addr = a;
    @(posedge ref_clk);
    #1;
    sfr_rd = 1'b0;
    chk(nm, e, sfr_rdata);
  endtask : rchk

  task automatic obj_wr(input logic [3:0] o, input logic [7:0] a,
    input logic [7:0] d);
    wr(ADDR_PAGE, {o, 4'h0});
    wr(a, d);
  endtask : obj_wr

  task automatic obj_chk(input string nm, input logic [3:0] o,
    input logic [7:0] a, input logic [7:0] e);
    wr(ADDR_PAGE, {o, 4'h0});
    rchk(nm, a, e);
  endtask : obj_chk

  task automatic wait_for(input bit idle);
    int i;
    for (i = 0; i < 50; i++) begin
      if (idle ? tx_busy === 1'b0 : tx_start === 1'b1) break;
      @(posedge ref_clk);
      #1;
    end
    if (i == 50) begin
      bad_count++;
      $display("Error transmit wait expected event seen none");
      close_out();
    end
  endtask : wait_for

  initial begin
    {rst_b, sfr_wr, sfr_rd} = '0;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    repeat (20) @(posedge ref_clk);
    #1;
    rst_b = 1'b1;
    rchk("page", ADDR_PAGE, PAGE_RST);
    rchk("status", ADDR_STAT, STAT_RST);
    rchk("control", ADDR_CTRL, CTRL_RST);
    rchk("unmapped", 8'hb7, READ_NONE);
    obj_wr(4'hf, ADDR_CTRL, 8'h48);
    rchk("obj15", ADDR_CTRL, READ_NONE);
    wr(ADDR_PAGE, 8'h20);
    rchk("page obj2", ADDR_PAGE, 8'h20);
    rchk("obj2 ctrl", ADDR_CTRL, 8'h00);
    $display("Test page select done");
    wr(ADDR_PAGE, 8'h06);
    wr(ADDR_DATA, 8'h11);
    wr(ADDR_DATA, 8'h22);
    wr(ADDR_DATA, 8'h33);
    rchk("index", ADDR_PAGE, 8'h01);
    wr(ADDR_PAGE, 8'h06);
    rchk("byte6", ADDR_DATA, 8'h11);
    rchk("byte7", ADDR_DATA, 8'h22);
    rchk("byte0", ADDR_DATA, 8'h33);
    wr(ADDR_PAGE, 8'h0f);
    rchk("held", ADDR_DATA, 8'h22);
    rchk("held", ADDR_DATA, 8'h22);
    rchk("page held", ADDR_PAGE, 8'h0f);
    $display("Test data index done");
    obj_wr(4'h5, ADDR_CTRL, 8'h48);
    obj_wr(4'h3, ADDR_CTRL, 8'h52);
    node_inst.ready(1'b1);
    wait_for(1'b0);
    chk("tx obj", 8'h03, {4'h0, tx_obj});
    chk("tx ide", 8'h01, {7'h00, tx_ide});
    chk("tx dlc", 8'h02, {4'h0, tx_dlc});
    node_inst.err_pulse(5'h11);
    wait_for(1'b1);
    wait_for(1'b0);
    chk("tx obj", 8'h05, {4'h0, tx_obj});
    chk("tx dlc", 8'h08, {4'h0, tx_dlc});
    wait_for(1'b1);
    node_inst.ready(1'b0);
    obj_chk("obj3 status", 4'h3, ADDR_STAT, 8'h51);
    obj_chk("obj3 ctrl", 4'h3, ADDR_CTRL, 8'h12);
    obj_chk("obj5 status", 4'h5, ADDR_STAT, 8'h40);
    $display("Test transmit done");
    obj_wr(4'h1, ADDR_CTRL, 8'h84);
    obj_wr(4'h2, ADDR_CTRL, 8'h84);
    node_inst.rx_frame(15'h0006, 4'h6, 1'b0);
    chk("rx upd", 8'h01, {7'h00, rx_upd});
    chk("rx obj", 8'h01, {4'h0, rx_obj});
    obj_chk("obj1 ctrl", 4'h1, ADDR_CTRL, 8'h06);
    obj_chk("obj1 status", 4'h1, ADDR_STAT, 8'ha0);
    node_inst.rx_frame(15'h0006, 4'h4, 1'b0);
    chk("rx obj", 8'h02, {4'h0, rx_obj});
    obj_chk("obj2 status", 4'h2, ADDR_STAT, 8'h20);
    node_inst.err_pulse(ERR_ANY);
    obj_chk("obj2 errors", 4'h2, ADDR_STAT, 8'h2e);
    wr(ADDR_STAT, 8'h00);
    rchk("cleared", ADDR_STAT, 8'h00);
    $display("Test receive done");
    obj_wr(4'h4, ADDR_CTRL, 8'ha3);
    obj_wr(4'h6, ADDR_CTRL, 8'h83);
    node_inst.rx_frame(15'h0050, 4'h3, 1'b1);
    obj_chk("reply", 4'h4, ADDR_CTRL, 8'h63);
    node_inst.rx_frame(15'h0040, 4'h3, 1'b1);
    obj_chk("no reply", 4'h6, ADDR_CTRL, 8'h03);
    $display("Test auto reply done");
    close_out();
  end
endmodule : tb_cmpo_obj_page
